/* File: i2c_buf_pkg.sv */
// Purpose: Shared constants for the I2C buffer and own-address block
// Assumes: Word-indexed register port, 16-bit register data
// Notes: Offsets are register indices
package i2c_buf_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_THRESH = 4'h1;
    localparam logic [3:0] OFF_RXBUF = 4'h2;
    localparam logic [3:0] OFF_TXBUF = 4'h3;
    localparam logic [3:0] OFF_OA0 = 4'h4;
    localparam logic [3:0] OFF_OA1 = 4'h5;
    localparam logic [3:0] OFF_IRQ_STAT = 4'h6;
    localparam logic [3:0] OFF_IRQ_MASK = 4'h7;
    localparam logic [3:0] OFF_STATUS = 4'h8;
    // Control register fields
    localparam int CTRL_SOFT_RESET = 0;
    localparam int CTRL_TEN_BIT = 1;
    localparam int CTRL_ASTP_LO = 2;
    localparam int CTRL_STOP_REQ = 4;
    localparam logic [15:0] CTRL_RESET = 16'h0001;
    // Own-address fields
    localparam int OA_GC_BIT = 15;
    localparam int OA_EN_BIT = 10;
    localparam logic [15:0] OA0_MASK = 16'h87ff;
    localparam logic [15:0] OA1_MASK = 16'h07ff;
    localparam logic [9:0] ADDR7_MASK = 10'h07f;
    localparam logic [9:0] GENERAL_CALL = 10'h000;
    // Auto-stop selections
    localparam logic [1:0] ASTP_NONE = 2'h0;
    localparam logic [1:0] ASTP_FLAG = 2'h1;
    localparam logic [1:0] ASTP_STOP = 2'h2;
    // Interrupt bits
    localparam int IRQ_RX = 0;
    localparam int IRQ_TX = 1;
    localparam int IRQ_CNT = 2;
    localparam int IRQ_STOP = 3;
    localparam int IRQ_W = 4;
endpackage

/* File: i2c_buffers_own_address.sv */
// Purpose: Data buffers, byte threshold, own-address match of an I2C block
// Assumes: Shift engine outside; its strobes sampled through two flops
// Notes: Link clock is sampled, not used as a clock
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ps
module i2c_buffers_own_address
    import i2c_buf_pkg::*;
#(
    parameter int THRESH_W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Register port
    input wire logic [i2c_buf_pkg::ADDR_W-1:0] regAddr,
    input wire logic [i2c_buf_pkg::DATA_W-1:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [i2c_buf_pkg::DATA_W-1:0] regRdata,
    // Shift engine, link-clock domain
    input wire logic linkClk,
    input wire logic rxByteValid,
    input wire logic [7:0] rxShiftByte,
    input wire logic txByteTaken,
    input wire logic addrValid,
    input wire logic [9:0] rxAddr,
    input wire logic byteDone,
    input wire logic startSeen,
    // Results
    output logic addrMatch,
    output logic generalCallHit,
    output logic autoStop,
    output logic [7:0] txByteOut,
    output logic irq
);
    import i2c_buf_pkg::*;

    if (THRESH_W != 8) begin : gen_width_check
        $error("THRESH_W must be 8");
    end

    //------------------------------------------------------------
    // Input synchronisers
    //------------------------------------------------------------
    logic [5:0] syncA_q, syncB_q, syncC_q;
    logic [17:0] dataA_q, dataB_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            syncA_q <= 6'h00;
            syncB_q <= 6'h00;
            syncC_q <= 6'h00;
            dataA_q <= 18'h00000;
            dataB_q <= 18'h00000;
        end else begin
            syncA_q <= {linkClk, rxByteValid, txByteTaken, addrValid, byteDone,
                        startSeen};
            syncB_q <= syncA_q;
            syncC_q <= syncB_q;
            dataA_q <= {rxShiftByte, rxAddr};
            dataB_q <= dataA_q;
        end
    end
    // Rising edges of the synchronised strobes
    logic [5:0] rise;
    assign rise = syncB_q & ~syncC_q;
    logic rxEv, txEv, addrEv, byteEv, startEv;
    assign rxEv = rise[4];
    assign txEv = rise[3];
    assign addrEv = rise[2];
    assign byteEv = rise[1];
    assign startEv = rise[0];

    //------------------------------------------------------------
    // Registers
    //------------------------------------------------------------
    logic [15:0] ctrl_q, oa0_q, oa1_q;
    logic [7:0] thresh_q, rxBuf_q, txBuf_q, byteCnt_q;
    logic [IRQ_W-1:0] irqStat_q, irqMask_q;
    logic softReset, tenBit;
    logic [1:0] astpSel;
    assign softReset = ctrl_q[CTRL_SOFT_RESET];
    assign tenBit = ctrl_q[CTRL_TEN_BIT];
    assign astpSel = ctrl_q[CTRL_ASTP_LO+1:CTRL_ASTP_LO];

    logic wrCtrl, wrThr, wrTx, wrOa0, wrOa1, wrMask, rdRx, rdStat;
    assign wrCtrl = regWr && regAddr == OFF_CTRL;
    assign wrThr = regWr && regAddr == OFF_THRESH;
    assign wrTx = regWr && regAddr == OFF_TXBUF;
    assign wrOa0 = regWr && regAddr == OFF_OA0;
    assign wrOa1 = regWr && regAddr == OFF_OA1;
    assign wrMask = regWr && regAddr == OFF_IRQ_MASK;
    assign rdRx = regRd && regAddr == OFF_RXBUF;
    assign rdStat = regRd && regAddr == OFF_IRQ_STAT;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= CTRL_RESET;
        end else if (wrCtrl) begin
            ctrl_q <= {12'h000, regWdata[CTRL_ASTP_LO+1:0]};
        end
    end

    // Configuration writes; software keeps them to soft reset time
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            thresh_q <= 8'h00;
            oa0_q <= 16'h0000;
            oa1_q <= 16'h0000;
            irqMask_q <= '0;
        end else begin
            if (wrThr) thresh_q <= regWdata[7:0];
            if (wrOa0) oa0_q <= regWdata & OA0_MASK;
            if (wrOa1) oa1_q <= regWdata & OA1_MASK;
            if (wrMask) irqMask_q <= regWdata[IRQ_W-1:0];
        end
    end

    // Receive and transmit buffers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rxBuf_q <= 8'h00;
            txBuf_q <= 8'h00;
        end else begin
            if (rxEv && !softReset) rxBuf_q <= dataB_q[17:10];
            if (wrTx) txBuf_q <= regWdata[7:0];
        end
    end

    //------------------------------------------------------------
    // Byte counter and auto stop
    //------------------------------------------------------------
    logic thrHit;
    assign thrHit = byteEv && !softReset && astpSel != ASTP_NONE
                    && (byteCnt_q + 8'h01) == thresh_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            byteCnt_q <= 8'h00;
        end else if (softReset || startEv) begin
            byteCnt_q <= 8'h00;
        end else if (byteEv) begin
            byteCnt_q <= byteCnt_q + 8'h01;
        end
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            autoStop <= 1'b0;
        end else begin
            autoStop <= (thrHit && astpSel == ASTP_STOP)
                        || (wrCtrl && regWdata[CTRL_STOP_REQ]);
        end
    end

    //------------------------------------------------------------
    // Interrupt flags: set beats clear
    //------------------------------------------------------------
    logic [IRQ_W-1:0] setEv, clrEv;
    always_comb begin
        setEv = '0;
        clrEv = '0;
        setEv[IRQ_RX] = rxEv && !softReset;
        setEv[IRQ_TX] = txEv || (wrCtrl && regWdata[CTRL_SOFT_RESET] && !softReset);
        setEv[IRQ_CNT] = thrHit;
        setEv[IRQ_STOP] = thrHit && astpSel == ASTP_STOP;
        if (rdStat) clrEv = '1;
        clrEv[IRQ_RX] = clrEv[IRQ_RX] | rdRx;
        clrEv[IRQ_TX] = clrEv[IRQ_TX] | wrTx;
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irqStat_q <= '0;
        end else begin
            irqStat_q <= (irqStat_q & ~clrEv) | setEv;
        end
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((irqStat_q & ~clrEv) | setEv) & irqMask_q);
        end
    end

    //------------------------------------------------------------
    // Own-address matching
    //------------------------------------------------------------
    logic [9:0] cmpMask;
    logic hit0, hit1, gcHit;
    assign cmpMask = tenBit ? 10'h3ff : ADDR7_MASK;
    assign hit0 = oa0_q[OA_EN_BIT] && ((oa0_q[9:0] ^ dataB_q[9:0]) & cmpMask) == 10'h000;
    assign hit1 = oa1_q[OA_EN_BIT] && ((oa1_q[9:0] ^ dataB_q[9:0]) & cmpMask) == 10'h000;
    assign gcHit = oa0_q[OA_GC_BIT] && !tenBit
                   && (dataB_q[9:0] & ADDR7_MASK) == GENERAL_CALL;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            addrMatch <= 1'b0;
            generalCallHit <= 1'b0;
        end else if (softReset || startEv) begin
            addrMatch <= 1'b0;
            generalCallHit <= 1'b0;
        end else if (addrEv) begin
            addrMatch <= hit0 || hit1 || gcHit;
            generalCallHit <= gcHit;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            txByteOut <= 8'h00;
        end else begin
            txByteOut <= txBuf_q;
        end
    end

    //------------------------------------------------------------
    // Read port
    //------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            regRdata <= 16'h0000;
        end else if (regRd) begin
            case (regAddr)
                OFF_CTRL: regRdata <= ctrl_q;
                OFF_THRESH: regRdata <= {8'h00, thresh_q};
                OFF_RXBUF: regRdata <= {8'h00, rxBuf_q};
                OFF_TXBUF: regRdata <= {8'h00, txBuf_q};
                OFF_OA0: regRdata <= oa0_q;
                OFF_OA1: regRdata <= oa1_q;
                OFF_IRQ_STAT: regRdata <= {12'h000, irqStat_q};
                OFF_IRQ_MASK: regRdata <= {12'h000, irqMask_q};
                OFF_STATUS: regRdata <= {byteCnt_q, 6'h00, generalCallHit, addrMatch};
                default: regRdata <= 16'h0000;
            endcase
        end else begin
            regRdata <= 16'h0000;
        end
    end

    //------------------------------------------------------------
    // Checks
    //------------------------------------------------------------
    sequence rxReadSeq;
        regRd && regAddr == OFF_RXBUF && !rxEv;
    endsequence
    AST_RX_CLEAR: assert property (@(posedge clk) disable iff (!rst_b)
        rxReadSeq |=> !irqStat_q[IRQ_RX]) else $error("rx flag not cleared");
    AST_TX_CLEAR: assert property (@(posedge clk) disable iff (!rst_b)
        wrTx && !txEv |=> !irqStat_q[IRQ_TX]) else $error("tx flag not cleared");
    AST_THR_IGNORED: assert property (@(posedge clk) disable iff (!rst_b)
        astpSel == ASTP_NONE && !wrCtrl |=> !$rose(irqStat_q[IRQ_CNT]) && !autoStop)
        else $error("threshold used in mode zero");
    AST_AUTO_STOP: assert property (@(posedge clk) disable iff (!rst_b)
        thrHit && astpSel == ASTP_STOP |=> autoStop && irqStat_q[IRQ_CNT])
        else $error("auto stop missing");
    AST_FLAG_ONLY: assert property (@(posedge clk) disable iff (!rst_b)
        thrHit && astpSel == ASTP_FLAG && !wrCtrl |=> !autoStop && irqStat_q[IRQ_CNT])
        else $error("flag mode misbehaves");
    AST_RX_LOAD: assert property (@(posedge clk) disable iff (!rst_b)
        rxEv && !softReset |=> rxBuf_q == $past(dataB_q[17:10])) else $error("rx byte lost");
    AST_OA1_NO_GC: assert property (@(posedge clk) disable iff (!rst_b)
        oa1_q[OA_GC_BIT] == 1'b0) else $error("slot one holds gc enable");
    AST_GC_OFF: assert property (@(posedge clk) disable iff (!rst_b)
        addrEv && !softReset && !startEv && !oa0_q[OA_GC_BIT] |=> !generalCallHit)
        else $error("general call answered while disabled");
    AST_MATCH_DISABLED: assert property (@(posedge clk) disable iff (!rst_b)
        addrEv && !startEv && !oa0_q[OA_EN_BIT] && !oa1_q[OA_EN_BIT] && !gcHit
        |=> !addrMatch) else $error("disabled address matched");
    AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (!rst_b)
        $past(regRd) && $past(regAddr) == OFF_THRESH |-> regRdata[15:8] == 8'h00)
        else $error("reserved bits not zero");

    //------------------------------------------------------------
    // Further checks
    //------------------------------------------------------------
    logic liveAddr;
    assign liveAddr = addrEv && !softReset && !startEv;
    // Software byte into the buffer, then onto the shifter side
    sequence txWriteSeq;
        wrTx;
    endsequence
    sequence txPassSeq;
        txBuf_q == $past(regWdata[7:0]) ##1 txByteOut == $past(regWdata[7:0], 2);
    endsequence
    AST_TX_LOAD: assert property (@(posedge clk) disable iff (!rst_b)
        txWriteSeq |=> txPassSeq)
        else $error("tx byte not passed on");
    AST_MATCH_7BIT: assert property (@(posedge clk) disable iff (!rst_b)
        liveAddr && !tenBit && oa0_q[OA_EN_BIT] && oa0_q[6:0] == dataB_q[6:0] |=> addrMatch)
        else $error("7-bit address not matched");
    AST_MATCH_10BIT: assert property (@(posedge clk) disable iff (!rst_b)
        liveAddr && tenBit && oa1_q[OA_EN_BIT] && oa1_q[9:0] == dataB_q[9:0] |=> addrMatch)
        else $error("10-bit address not matched");
    AST_GC_ON: assert property (@(posedge clk) disable iff (!rst_b)
        liveAddr && !tenBit && oa0_q[OA_GC_BIT] && dataB_q[6:0] == 7'h00 |=> generalCallHit)
        else $error("general call not answered");
    AST_START_CLEARS: assert property (@(posedge clk) disable iff (!rst_b)
        startEv |=> !addrMatch && !generalCallHit)
        else $error("match kept across start");
    AST_SOFT_NO_MATCH: assert property (@(posedge clk) disable iff (!rst_b)
        addrEv && softReset |=> !addrMatch)
        else $error("match during soft reset");
    AST_OA_RESERVED: assert property (@(posedge clk) disable iff (!rst_b)
        oa0_q[14:11] == 4'h0 && oa1_q[15:11] == 5'h00)
        else $error("own address reserved bits set");
    AST_CTRL_RESERVED: assert property (@(posedge clk) disable iff (!rst_b)
        ctrl_q[15:4] == 12'h000)
        else $error("control reserved bits set");
    AST_RX_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
        !(rxEv && !softReset) |=> $stable(rxBuf_q))
        else $error("rx buffer changed without a byte");
    AST_RX_FLAG_SET: assert property (@(posedge clk) disable iff (!rst_b)
        rxEv && !softReset |=> irqStat_q[IRQ_RX])
        else $error("rx flag not set");
    AST_RX_SET_WINS: assert property (@(posedge clk) disable iff (!rst_b)
        rxEv && !softReset && rdRx |=> irqStat_q[IRQ_RX])
        else $error("rx clear beat the set");
    AST_TX_SET_WINS: assert property (@(posedge clk) disable iff (!rst_b)
        txEv && wrTx |=> irqStat_q[IRQ_TX])
        else $error("tx clear beat the set");
    AST_THR_FLAG: assert property (@(posedge clk) disable iff (!rst_b)
        thrHit |=> irqStat_q[IRQ_CNT])
        else $error("count flag missing");
    AST_STOP_FLAG: assert property (@(posedge clk) disable iff (!rst_b)
        thrHit && astpSel == ASTP_STOP |=> irqStat_q[IRQ_STOP])
        else $error("stop flag missing");
    AST_STOP_PULSE: assert property (@(posedge clk) disable iff (!rst_b)
        autoStop && !wrCtrl && !thrHit |=> !autoStop)
        else $error("auto stop longer than one cycle");
    AST_CNT_CLEARED: assert property (@(posedge clk) disable iff (!rst_b)
        softReset || startEv |=> byteCnt_q == 8'h00)
        else $error("byte count not cleared");
endmodule

/* File: i2c_engine_model.sv */
// Purpose: Shift-engine stand-in driving the link-side strobes
// Assumes: Strobes held 4 clk high then 4 clk low
// Notes: Data lines show inverted values once released
`timescale 1ns/1ps
module i2c_engine_model (
    // Clock
    input wire logic clk,
    // Link side
    output logic linkClk,
    output logic rxByteValid,
    output logic [7:0] rxShiftByte,
    output logic txByteTaken,
    output logic addrValid,
    output logic [9:0] rxAddr,
    output logic byteDone,
    output logic startSeen
);
    logic run = 1'b0;
    initial begin
        {linkClk, rxByteValid, txByteTaken, addrValid, byteDone, startSeen} = 6'h00;
        rxShiftByte = 8'h00;
        rxAddr = 10'h000;
    end
    // Link clock only runs during an event
    always begin
        #32;
        if (run) linkClk = ~linkClk;
    end
    // Kinds: 0 rx byte, 1 tx taken, 2 address, 3 byte done, 4 start
    task automatic ev(input int k, input logic [9:0] v);
        run = 1'b1;
        @(posedge clk);
        rxShiftByte <= v[7:0];
        rxAddr <= v;
        case (k)
            0: rxByteValid <= 1'b1;
            1: txByteTaken <= 1'b1;
            2: addrValid <= 1'b1;
            3: byteDone <= 1'b1;
            default: startSeen <= 1'b1;
        endcase
        repeat (4) @(posedge clk);
        {rxByteValid, txByteTaken, addrValid, byteDone, startSeen} <= 5'h00;
        repeat (4) @(posedge clk);
        rxShiftByte <= ~v[7:0];
        rxAddr <= ~v;
        run = 1'b0;
    endtask
endmodule

/* File: test_i2c_buffers_own_address.sv */
// Purpose: Register-level tests of buffers, threshold and own address
// Assumes: Register read data valid one cycle after the strobe
// Notes: Link events come from the engine model
`timescale 1ns/1ps
module test_i2c_buffers_own_address;
    import i2c_buf_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [15:0] regWdata = 16'h0000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [15:0] regRdata, d, c;
    logic linkClk, rxByteValid, txByteTaken, addrValid, byteDone, startSeen;
    logic [7:0] rxShiftByte, txByteOut;
    logic [9:0] rxAddr;
    logic addrMatch, generalCallHit, autoStop, irq;
    logic [3:0] regs [4] = '{OFF_THRESH, OFF_TXBUF, OFF_OA0, OFF_OA1};
    logic [15:0] masks [4] = '{16'h00ff, 16'h00ff, OA0_MASK, OA1_MASK};
    int failures = 0;
    int n_checks = 0;
    int stops = 0;
    always #2 clk = ~clk;
    always @(posedge clk) if (autoStop === 1'b1) stops++;
    i2c_buffers_own_address uut (.clk(clk), .rst_b(rst_b), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .linkClk(linkClk), .rxByteValid(rxByteValid), .rxShiftByte(rxShiftByte),
        .txByteTaken(txByteTaken), .addrValid(addrValid), .rxAddr(rxAddr),
        .byteDone(byteDone), .startSeen(startSeen), .addrMatch(addrMatch),
        .generalCallHit(generalCallHit), .autoStop(autoStop), .txByteOut(txByteOut),
        .irq(irq));
    i2c_engine_model eng (.clk(clk), .linkClk(linkClk), .rxByteValid(rxByteValid),
        .rxShiftByte(rxShiftByte), .txByteTaken(txByteTaken), .addrValid(addrValid),
        .rxAddr(rxAddr), .byteDone(byteDone), .startSeen(startSeen));
    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk);
        regAddr <= a;
        regWdata <= v;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 v = regRdata;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
        logic [15:0] v;
        rd(a, v);
        chk(v, exp);
    endtask
    task automatic cfg(input logic [15:0] ct, th, o0, o1);
        wr(OFF_CTRL, 16'h0001);
        wr(OFF_THRESH, th);
        wr(OFF_OA0, o0);
        wr(OFF_OA1, o1);
        wr(OFF_CTRL, ct);
    endtask
    task automatic probe(input logic [9:0] a, input logic m, g);
        eng.ev(2, a);
        chk(addrMatch, m);
        chk(generalCallHit, g);
    endtask
    task automatic complete_run;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        #100000;
        failures++;
        complete_run();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        rdc(OFF_CTRL, CTRL_RESET);
        rdc(OFF_THRESH, 16'h0000);
        wr(4'hf, 16'hffff);
        rdc(4'hf, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            wr(regs[i], 16'hffff);
            rdc(regs[i], masks[i]);
        end
        chk(txByteOut, 16'h00ff);
        wr(OFF_IRQ_MASK, 16'h0001);
        wr(OFF_CTRL, 16'h0000);
        rd(OFF_IRQ_STAT, d);
        eng.ev(0, 10'h0a5);
        chk(irq, 1'b1);
        rdc(OFF_RXBUF, 16'h00a5);
        repeat (3) @(posedge clk);
        chk(irq, 1'b0);
        wr(OFF_IRQ_MASK, 16'h0002);
        eng.ev(1, 10'h000);
        chk(irq, 1'b1);
        wr(OFF_TXBUF, 16'h005a);
        repeat (3) @(posedge clk);
        chk(irq, 1'b0);
        chk(txByteOut, 16'h005a);
        cfg(16'h0000, 16'h0000, 16'h0448, 16'h0052);
        probe(10'h048, 1'b1, 1'b0);
        probe(10'h3c8, 1'b1, 1'b0);
        probe(10'h052, 1'b0, 1'b0);
        probe(10'h000, 1'b0, 1'b0);
        cfg(16'h0000, 16'h0000, 16'h8448, 16'h0452);
        probe(10'h000, 1'b1, 1'b1);
        probe(10'h052, 1'b1, 1'b0);
        cfg(16'h0002, 16'h0000, 16'h0000, 16'h06c8);
        probe(10'h2c8, 1'b1, 1'b0);
        probe(10'h0c8, 1'b0, 1'b0);
        wr(OFF_IRQ_MASK, 16'h0004);
        // Selections 0, 1, 2, then 0 with a stop request
        for (int s = 0; s < 4; s++) begin
            c = (s == 3) ? 16'h0000 : 16'(s << 2);
            cfg(c, 16'h0003, 16'h0000, 16'h0000);
            rd(OFF_IRQ_STAT, d);
            eng.ev(4, 10'h000);
            stops = 0;
            repeat (2) eng.ev(3, 10'h000);
            chk(irq, 1'b0);
            eng.ev(3, 10'h000);
            if (s == 3) wr(OFF_CTRL, 16'h0010);
            repeat (3) @(posedge clk);
            chk(irq, s == 1 || s == 2);
            chk(16'(stops), 16'(s >= 2));
            rdc(OFF_STATUS, 16'h0300);
            rdc(OFF_IRQ_STAT, {12'h000, s == 2, s == 1 || s == 2, 2'b00});
        end
        complete_run();
    end
endmodule
